//--- src/itmr_regs.svh
// Constants for the interval timer: widths, encodings, timebase figures
`ifndef ITMR_REGS_SVH
`define ITMR_REGS_SVH
`define ITMR_CNT_W 16
`define ITMR_ALL_ONES 16'hFFFF
`define ITMR_ZERO 16'h0000
`define ITMR_MODE_SINGLE 1'b0
`define ITMR_MODE_RECYCLE 1'b1
`define ITMR_CLK_MHZ 50
`define ITMR_PERIOD_US 1
`define ITMR_DIV_W 16
`endif

//--- src/itmr_pkg.sv
// Types shared by the interval timer files
package itmr_pkg;
    // Host command strobes and data
    typedef struct packed {
        logic cmd_stb;
        logic cmd_recycle;
        logic data_stb;
        logic [15:0] data;
        logic ack;
    } itmr_host_t;
    typedef enum logic [2:0] {
        ITMR_IDLE = 3'b001,
        ITMR_RUN = 3'b010,
        ITMR_DONE = 3'b100
    } itmr_state_t;
endpackage

//--- src/itmr_tick.sv
// Timebase tick generator: internal divider or external clock edge
`timescale 1ns/10ps
`default_nettype none
`include "itmr_regs.svh"
module itmr_tick #(
    parameter int unsigned PERIOD_US = `ITMR_PERIOD_US,
    parameter bit USE_EXT = 1'b0
) (
    // Clock, reset, enable
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Restart and external clock
    input wire logic restart_i,
    input wire logic ext_clk_i,
    // Tick out
    output logic tick_o
);
    localparam int unsigned DIV_CYC = PERIOD_US * `ITMR_CLK_MHZ;
    localparam logic [`ITMR_DIV_W-1:0] DIV_LAST = `ITMR_DIV_W'(DIV_CYC - 1);
    logic [`ITMR_DIV_W-1:0] div_reg;
    logic ext_d_reg;
    // Divider restarts with each load so the first period is whole
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            div_reg <= `ITMR_DIV_W'h0;
        end else if (ce_i) begin
            if (restart_i || div_reg == DIV_LAST) begin
                div_reg <= `ITMR_DIV_W'h0;
            end else begin
                div_reg <= div_reg + `ITMR_DIV_W'h1;
            end
        end
    end
    // External clock is synchronous; rising edge gives one tick
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            ext_d_reg <= 1'b0;
        end else if (ce_i) begin
            ext_d_reg <= ext_clk_i;
        end
    end
    assign tick_o = ce_i && !restart_i && (USE_EXT ? (ext_clk_i && !ext_d_reg)
                                                  : (div_reg == DIV_LAST));
endmodule
`default_nettype wire

//--- src/itmr_top.sv
// Interval timer: 16-bit up counter loaded with complement of interval
`timescale 1ns/10ps
`default_nettype none
`include "itmr_regs.svh"
// Overview of operation
// (R1) Sixteen-bit counter; host sets interval and reads current value.
// (R2) Counter advances on one fixed timebase: internal period or external clock.
// (R3) Output command selects recycle or single mode; timer latches the choice.
// (R4) Data write stores holding value and loads its complement, counting starts.
// (R5) Counter at all ones signals end of interval to control.
// (R6) Single mode: raise interrupt at end, then stop until reloaded.
// (R7) Recycle mode: raise interrupt, reload from holding register, keep timing.
// (R8) Data write during an interval restarts count without an interrupt.
// (R9) Data read returns current count anytime without disturbing counting.
// (R10) One increment per timebase period; request held until ack, command or write.
module itmr_top
    import itmr_pkg::*;
#(
    parameter int unsigned PERIOD_US = `ITMR_PERIOD_US,
    parameter bit USE_EXT = 1'b0
) (
    // Clock, reset, enable
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Host I/O bus
    input wire logic cmd_stb_i,
    input wire logic cmd_recycle_i,
    input wire logic data_stb_i,
    input wire logic [`ITMR_CNT_W-1:0] data_i,
    input wire logic ack_i,
    // External timebase
    input wire logic ext_clk_i,
    // Outputs to host
    output logic [`ITMR_CNT_W-1:0] count_o,
    output logic running_o,
    output logic mode_recycle_o,
    output logic irq_o
);
    // Host bus strobes as one bundle
    itmr_host_t host;

    // Control state and data registers
    itmr_state_t state_reg;
    logic [`ITMR_CNT_W-1:0] hold_reg;
    logic [`ITMR_CNT_W-1:0] cnt_reg;
    logic mode_reg;
    logic irq_reg;

    // Qualified events; each one except restart already carries the clock enable
    logic tick;
    logic restart;
    logic end_int;
    logic load_evt;
    logic cmd_evt;
    logic step_evt;
    logic irq_set;
    logic irq_clr;

    // Fixed figures under local names, so the logic reads as intent
    localparam logic [`ITMR_CNT_W-1:0] CNT_ONE = `ITMR_CNT_W'h1;
    localparam logic [`ITMR_CNT_W-1:0] CNT_CLEAR = `ITMR_ZERO;
    localparam logic MODE_AT_RESET = `ITMR_MODE_SINGLE;

    // True while an interval is being timed
    function automatic logic is_running(input itmr_state_t s);
        return (s == ITMR_RUN);
    endfunction

    // Counter start value for an interval is its complement
    function automatic logic [`ITMR_CNT_W-1:0] start_value(input logic [`ITMR_CNT_W-1:0] v);
        return ~v;
    endfunction

    // One step of the counter; wraps only through a reload
    function automatic logic [`ITMR_CNT_W-1:0] next_count(input logic [`ITMR_CNT_W-1:0] c);
        return c + CNT_ONE;
    endfunction

    // Counter sits at the last value of an interval
    function automatic logic at_last(input logic [`ITMR_CNT_W-1:0] c);
        return (c == `ITMR_ALL_ONES);
    endfunction

    // Latched mode says the next interval starts by itself
    function automatic logic is_recycle(input logic m);
        return (m == `ITMR_MODE_RECYCLE);
    endfunction

    // Any host action that retires a standing request
    function automatic logic clears_irq(input itmr_host_t h);
        return h.ack || h.cmd_stb || h.data_stb;
    endfunction

    // Group the host strobes
    assign host = '{
        cmd_stb: cmd_stb_i,
        cmd_recycle: cmd_recycle_i,
        data_stb: data_stb_i,
        data: data_i,
        ack: ack_i
    };

    // Host events count only while the clock enable is high
    assign load_evt = ce_i && host.data_stb;
    assign cmd_evt = ce_i && host.cmd_stb;
    assign step_evt = is_running(state_reg) && tick; // R10

    // A write restarts the divider so the first period is whole
    assign restart = host.data_stb;

    // Timebase
    itmr_tick #(
        .PERIOD_US(PERIOD_US),
        .USE_EXT(USE_EXT)
    ) u_tick (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .restart_i(restart),
        .ext_clk_i(ext_clk_i),
        .tick_o(tick)
    ); // R2

    // End of interval: counter at all ones while running, on a tick
    // Ticks are a whole period apart, so an end fires once per interval
    assign end_int = step_evt && at_last(cnt_reg); // R5

    // A write on the end cycle wins, so no request follows a restart
    assign irq_set = end_int && !host.data_stb; // R8
    // Set beats clear when both fall in one cycle
    assign irq_clr = ce_i && clears_irq(host);

    // Mode latch, kept across intervals
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            mode_reg <= MODE_AT_RESET;
        end else if (cmd_evt) begin
            mode_reg <= host.cmd_recycle; // R3
        end
    end

    // Holding register takes each written interval
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            hold_reg <= CNT_CLEAR;
        end else if (load_evt) begin
            hold_reg <= host.data; // R4
        end
    end

    // Control sequence; a write always wins, so a pending end is dropped
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= ITMR_IDLE;
        end else if (ce_i) begin
            case (state_reg)
                ITMR_IDLE: begin
                    // Nothing to time until the first interval is written
                    if (host.data_stb) begin
                        state_reg <= ITMR_RUN; // R4
                    end
                end
                ITMR_RUN: begin
                    if (host.data_stb) begin
                        state_reg <= ITMR_RUN; // R8
                    end else if (end_int && !is_recycle(mode_reg)) begin
                        state_reg <= ITMR_DONE; // R6
                    end
                end
                ITMR_DONE: begin
                    // Single mode rests here; a command alone does not restart
                    if (host.data_stb) begin
                        state_reg <= ITMR_RUN; // R4
                    end
                end
                default: begin
                    state_reg <= ITMR_IDLE;
                end
            endcase
        end
    end

    // Counter: load complement, step once per tick, reload in recycle
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_reg <= CNT_CLEAR;
        end else if (load_evt) begin
            cnt_reg <= start_value(host.data); // R4 R8
        end else if (end_int) begin
            if (is_recycle(mode_reg)) begin
                cnt_reg <= start_value(hold_reg); // R7
            end else begin
                cnt_reg <= cnt_reg; // R6
            end
        end else if (step_evt) begin
            cnt_reg <= next_count(cnt_reg); // R10
        end
    end

    // Interrupt request: held until ack, a command or a write
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_reg <= 1'b0;
        end else if (irq_set) begin
            irq_reg <= 1'b1; // R6 R7
        end else if (irq_clr) begin
            irq_reg <= 1'b0; // R10
        end
    end

    // Read path is a plain view of the counter, never a side effect
    assign count_o = cnt_reg; // R1 R9
    // Status levels straight from registers
    assign running_o = is_running(state_reg);
    assign mode_recycle_o = mode_reg;
    assign irq_o = irq_reg;
endmodule
`default_nettype wire

//--- dv/itmr_top_monitor.sv
// Port-level checks for the interval timer
`timescale 1ns/10ps
`default_nettype none
module itmr_top_monitor (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // Host side
    input wire logic ce_i,
    input wire logic cmd_stb_i,
    input wire logic cmd_recycle_i,
    input wire logic data_stb_i,
    input wire logic [15:0] data_i,
    input wire logic ack_i,
    // Timer outputs
    input wire logic [15:0] count_o,
    input wire logic running_o,
    input wire logic mode_recycle_o,
    input wire logic irq_o
);
    // Single domain, so one clock and one disable serve every check
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);
    chk_load_cmpl: assert property (ce_i && data_stb_i |=> count_o == ~$past(data_i) && running_o)
        else $error("load mismatch");
    chk_mode_latch: assert property (ce_i && cmd_stb_i |=> mode_recycle_o == $past(cmd_recycle_i))
        else $error("mode not latched");
    chk_write_quiet: assert property (ce_i && data_stb_i |=> !irq_o)
        else $error("irq after write");
    chk_irq_cause: assert property ($rose(irq_o) |-> $past(count_o) == 16'hFFFF)
        else $error("irq without end");
    chk_single_stop: assert property ($rose(irq_o) && !mode_recycle_o |-> !running_o && count_o == 16'hFFFF)
        else $error("single did not stop");
    chk_recycle_go: assert property ($rose(irq_o) && mode_recycle_o |-> running_o ##1 running_o)
        else $error("recycle stopped");
    // Reload at all ones is exempt, elsewhere only hold or plus one
    chk_step_one: assert property (running_o && !data_stb_i && count_o != 16'hFFFF |=> count_o == $past(count_o) || count_o == $past(count_o) + 16'h0001)
        else $error("count jumped");
    chk_idle_hold: assert property (!running_o && !data_stb_i |=> $stable(count_o))
        else $error("idle count moved");
    chk_irq_hold: assert property (irq_o && !ack_i && !cmd_stb_i && !data_stb_i |=> irq_o)
        else $error("irq dropped");
endmodule
bind itmr_top itmr_top_monitor itmr_top_monitor_inst (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i),
    .cmd_stb_i(cmd_stb_i), .cmd_recycle_i(cmd_recycle_i), .data_stb_i(data_stb_i),
    .data_i(data_i), .ack_i(ack_i), .count_o(count_o), .running_o(running_o),
    .mode_recycle_o(mode_recycle_o), .irq_o(irq_o));
`default_nettype wire

//--- dv/itmr_host_model.sv
// Host model that acknowledges a standing interrupt request
`timescale 1ns/10ps
`default_nettype none
module itmr_host_model #(
    parameter int LAT = 2
) (
    // Clock and control
    input wire logic mclk_i,
    input wire logic en_i,
    // Request and acknowledge
    input wire logic irq_i,
    output logic ack_o
);
    int wait_cnt = 0;
    initial ack_o = 1'b0;
    // Slow on purpose, so the request has to stand for a while
    always @(posedge mclk_i) begin
        wait_cnt <= (irq_i && en_i) ? wait_cnt + 1 : 0;
        ack_o <= irq_i && en_i && wait_cnt >= LAT;
    end
endmodule
`default_nettype wire

//--- dv/tb_itmr_top.sv
// Self-checking bench for the interval timer
`timescale 1ns/10ps
`default_nettype none
module tb_itmr_top;
    import itmr_pkg::*;
    itmr_host_t h = '0;
    logic mclk_i = 1'b0, rst_i = 1'b1, ack, host_en = 1'b0, running, mode, irq, ce = 1'b1;
    logic [15:0] count, d;
    logic [31:0] rng = 32'h00018090;
    int error_cnt = 0, checks = 0, cyc = 0, n;
    itmr_top itmr_top_inst (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce),
        .cmd_stb_i(h.cmd_stb), .cmd_recycle_i(h.cmd_recycle), .data_stb_i(h.data_stb),
        .data_i(h.data), .ack_i(ack), .ext_clk_i(1'b0), .count_o(count),
        .running_o(running), .mode_recycle_o(mode), .irq_o(irq));
    itmr_host_model itmr_host_model_inst (.mclk_i(mclk_i), .en_i(host_en), .irq_i(irq), .ack_o(ack));
    always #10 mclk_i = ~mclk_i;
    // Hang guard, well above the longest interval run
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            summarize();
        end
    end
    function automatic logic [15:0] rnd();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng[15:0];
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One-cycle strobe: command takes mode from bit 0, write takes interval
    task automatic wr(input logic cmd, input logic [15:0] v);
        h.cmd_stb <= cmd;
        h.data_stb <= !cmd;
        h.data <= v;
        h.cmd_recycle <= v[0];
        @(posedge mclk_i);
        h <= '0;
        @(posedge mclk_i);
    endtask
    task automatic summarize();
        if (error_cnt == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge mclk_i);
        chk({count[15:1], running | mode | irq}, 16'h0000);
        rst_i <= 1'b0;
        @(posedge mclk_i);
        for (int m = 0; m < 4; m++) begin
            d = rnd() & 16'h0003;
            wr(1'b1, {15'h0000, m[0]});
            chk({15'h0000, mode}, {15'h0000, m[0]});
            wr(1'b0, d);
            chk(count, ~d);
            n = 0;
            while (irq !== 1'b1 && n < 300) begin
                @(negedge mclk_i);
                n++;
            end
            chk({15'h0000, n >= (d + 1) * 50 - 3 && n <= (d + 1) * 50 + 1}, 16'h0001);
            chk({15'h0000, running}, {15'h0000, m[0]});
            chk(count, m[0] ? ~d : 16'hFFFF);
            repeat (4) @(negedge mclk_i);
            chk({15'h0000, irq}, 16'h0001);
            @(posedge mclk_i) host_en <= 1'b1;
            repeat (6) @(negedge mclk_i);
            chk({15'h0000, irq}, 16'h0000);
            @(posedge mclk_i) host_en <= 1'b0;
        end
        // Enable low freezes count and timebase well past one period
        wr(1'b0, 16'h0002);
        ce <= 1'b0;
        repeat (120) @(posedge mclk_i);
        chk(count, 16'hFFFD);
        chk({15'h0000, irq | !running}, 16'h0000);
        ce <= 1'b1;
        // Rewrites every 62 cycles keep a 100-cycle interval from ending
        repeat (5) begin
            wr(1'b0, 16'h0001);
            repeat (60) @(posedge mclk_i);
        end
        @(negedge mclk_i);
        chk({15'h0000, irq}, 16'h0000);
        summarize();
    end
endmodule
`default_nettype wire
